// File: common/tbd_params.svh
// Constants for the twelve-bit instruction decoder: offsets, fields, timing
`ifndef TBD_PARAMS_SVH
`define TBD_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TBD_OFS_INSTR 4'h0
`define TBD_OFS_OPERAND 4'h4
`define TBD_OFS_RESULT 4'h8
`define TBD_OFS_STATUS 4'hC
// ----------------------------------------------------------------
// Special file addresses and field layout
// ----------------------------------------------------------------
`define TBD_FILE_TIMER 5'h01
`define TBD_FILE_PCL 5'h02
`define TBD_FILE_PORT 5'h06
`define TBD_TRISTATE_LOAD_PORT 3'h6
`define TBD_OPR_ACC_LSB 0
`define TBD_OPR_FILE_LSB 8
`define TBD_OPR_CARRY 16
`define TBD_OPR_DC 17
`define TBD_OPR_ZERO 18
`define TBD_OPR_PSA_TMR 19
// ----------------------------------------------------------------
// Reset values, timing and AXI response codes
// ----------------------------------------------------------------
`define TBD_TRISTATE_LOAD_RESET 8'hFF
`define TBD_OSC_PER_CYCLE 4
`define TBD_AXI_OKAY 2'h0
`define TBD_AXI_SLVERR 2'h2
`endif

// File: common/tbd_pkg.sv
// Types shared by the twelve-bit instruction decoder
package tbd_pkg;
  // Execution sequencer states, one-hot
  typedef enum logic [1:0] {
    TBD_IDLE = 2'b01,
    TBD_EXEC = 2'b10
  } tbd_state_type;
endpackage

// File: verilog/tbd_decoder.sv
// Twelve-bit instruction decoder with AXI4-Lite register access
`include "tbd_params.svh"
module tbd_decoder
  import tbd_pkg::*;
#(
  parameter int OSC_PER_CYCLE = `TBD_OSC_PER_CYCLE
)
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Port pins
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe_n,
  // Side effects
  output logic prescaler_clear,
  output logic standby
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] pin_meta_q, pin_q;
  logic [11:0] instr_q;
  logic [7:0] acc_q, file_q, tristate_load_q, latch_q, res_q;
  logic carry_q, dc_q, zero_q, psa_q, timeout_q, powerdown_q;
  logic [15:0] dec_q;
  logic [3:0] busy_q;
  tbd_state_type state_q;
  logic start;
  logic aw_held_q, w_held_q;
  logic [3:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [5:0] op6 = instr_q[11:6];
  wire dst_f = instr_q[5];
  wire [4:0] fsel = instr_q[4:0];
  wire [2:0] bsel = instr_q[7:5];
  wire [7:0] lit = instr_q[7:0];
  wire is_byte = instr_q[11:10] == 2'b00;
  wire is_misc = op6 == 6'h00 && !dst_f;
  wire is_bitset = instr_q[11:9] == 3'b010;
  wire is_btest = instr_q[11:9] == 3'b011;
  wire is_return_with_literal = instr_q[11:8] == 4'h8;
  wire is_call = instr_q[11:8] == 4'h9;
  wire is_unconditional_branch = instr_q[11:9] == 3'b101;
  wire is_sleep = instr_q == 12'h003;
  wire is_watchdog_clear = instr_q == 12'h004;
  wire is_tristate_load = is_misc && fsel[4:3] == 2'b00 && fsel[2:0] >= 3'h5;
  // Port reads use synchronised pin levels instead of the output latch
  wire [7:0] fv = (fsel == `TBD_FILE_PORT) ? pin_q : file_q;
  wire [8:0] sum9 = {1'b0, fv} + {1'b0, acc_q};
  wire [8:0] dif9 = {1'b0, fv} - {1'b0, acc_q};
  wire [4:0] sum_lo = {1'b0, fv[3:0]} + {1'b0, acc_q[3:0]};
  wire bit_val = fv[bsel];

  // ALU and flag selection
  logic [7:0] r;
  logic upd_z, upd_c, upd_dc, c_new, dc_new, wr_acc, wr_file, skip;
  always_comb
  begin
    r = 8'h00;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    c_new = carry_q;
    dc_new = dc_q;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    skip = 1'b0;
    if (is_byte && !is_misc)
    begin
      wr_acc = !dst_f;
      wr_file = dst_f;
      case (op6)
        6'h00: r = acc_q; // move acc to file
        6'h01: begin r = 8'h00; upd_z = 1'b1; end // clear file or accumulator
        6'h02: begin r = dif9[7:0]; c_new = !dif9[8]; dc_new = fv[3:0] >= acc_q[3:0];
          upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1; end
        6'h03: begin r = fv - 8'h01; upd_z = 1'b1; end
        6'h04: begin r = fv | acc_q; upd_z = 1'b1; end
        6'h05: begin r = fv & acc_q; upd_z = 1'b1; end
        6'h06: begin r = fv ^ acc_q; upd_z = 1'b1; end
        6'h07: begin r = sum9[7:0]; c_new = sum9[8]; dc_new = sum_lo[4];
          upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1; end
        6'h08: begin r = fv; upd_z = 1'b1; end
        6'h09: begin r = ~fv; upd_z = 1'b1; end
        6'h0A: begin r = fv + 8'h01; upd_z = 1'b1; end
        6'h0B: begin r = fv - 8'h01; skip = r == 8'h00; end
        6'h0C: begin r = {carry_q, fv[7:1]}; c_new = fv[0]; upd_c = 1'b1; end
        6'h0D: begin r = {fv[6:0], carry_q}; c_new = fv[7]; upd_c = 1'b1; end
        6'h0E: r = {fv[3:0], fv[7:4]};
        6'h0F: begin r = fv + 8'h01; skip = r == 8'h00; end
        default: r = fv;
      endcase
    end
    else if (is_bitset)
    begin
      r = fv;
      r[bsel] = instr_q[8];
      wr_file = 1'b1;
    end
    else if (is_btest)
    begin
      r = fv;
      skip = instr_q[8] ? bit_val : !bit_val;
    end
    else
    begin
      case (instr_q[11:8])
        4'h8: begin r = lit; wr_acc = 1'b1; end
        4'hC: begin r = lit; wr_acc = 1'b1; end
        4'hD: begin r = acc_q | lit; wr_acc = 1'b1; upd_z = 1'b1; end
        4'hE: begin r = acc_q & lit; wr_acc = 1'b1; upd_z = 1'b1; end
        4'hF: begin r = acc_q ^ lit; wr_acc = 1'b1; upd_z = 1'b1; end
        default: r = acc_q;
      endcase
    end
  end

  // Program counter effects and cycle count
  wire pcl_write = wr_file && fsel == `TBD_FILE_PCL;
  wire pc_write = is_unconditional_branch || is_call || is_return_with_literal || pcl_write;
  wire pc_bit8_clr = pc_write && !is_unconditional_branch;
  wire two_cycle = pc_write || skip;
  wire tristate_load_hit = is_tristate_load && fsel[2:0] == `TBD_TRISTATE_LOAD_PORT;
  wire tmr_hit = wr_file && fsel == `TBD_FILE_TIMER && psa_q;
  wire [3:0] cyc_clks = two_cycle ? 4'(2 * OSC_PER_CYCLE - 1) : 4'(OSC_PER_CYCLE - 1);
  wire [15:0] dec_word = {pc_bit8_clr, pc_write, two_cycle, skip, tristate_load_hit, tmr_hit,
    is_sleep, is_watchdog_clear, upd_dc, upd_c, upd_z, wr_file, wr_acc, dc_new, c_new, r == 8'h00};

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire wr_go = aw_held_q && w_held_q && !bvalid;
  wire [7:0] w_acc = ws_q[0] ? wd_q[7:0] : acc_q;
  wire [7:0] w_file = ws_q[1] ? wd_q[15:8] : file_q;
  wire wr_instr = wr_go && aw_q[3:2] == `TBD_OFS_INSTR >> 2 && state_q == TBD_IDLE;
  wire wr_opr = wr_go && aw_q[3:2] == `TBD_OFS_OPERAND >> 2;
  wire wr_bad = wr_go && !(wr_instr || wr_opr);
  // Readies drop while frozen so that no handshake is lost
  assign awready = ce && !aw_held_q;
  assign wready = ce && !w_held_q;
  assign arready = ce && !rvalid;
  assign start = wr_instr && ws_q[0];

  // Address and data capture, independent order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_q <= 4'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready) begin aw_held_q <= 1'b1; aw_q <= awaddr; end
      if (wvalid && wready) begin w_held_q <= 1'b1; wd_q <= wdata; ws_q <= wstrb; end
      if (wr_go) begin aw_held_q <= 1'b0; w_held_q <= 1'b0; end
    end
  end

  // Write response; busy instruction writes and unmapped offsets err
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `TBD_AXI_OKAY;
    end
    else if (ce)
    begin
      if (wr_go) begin bvalid <= 1'b1; bresp <= wr_bad ? `TBD_AXI_SLVERR : `TBD_AXI_OKAY; end
      else if (bready) bvalid <= 1'b0;
    end
  end

  // Read data mux
  logic [31:0] rd_mux;
  always_comb
  begin
    case (araddr[3:2])
      2'h0: rd_mux = {20'h0, instr_q};
      2'h1: rd_mux = {12'h0, psa_q, zero_q, dc_q, carry_q, file_q, acc_q};
      2'h2: rd_mux = {dec_q, 8'h0, res_q};
      default: rd_mux = {17'h0, busy_q, timeout_q, powerdown_q, state_q == TBD_EXEC, pin_q};
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `TBD_AXI_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready) begin rvalid <= 1'b1; rdata <= rd_mux; end
      else if (rready) rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin pin_meta_q <= 8'h00; pin_q <= 8'h00; end
    else if (ce) begin pin_meta_q <= port_pin_in; pin_q <= pin_meta_q; end
  end

  // ----------------------------------------------------------------
  // Execution sequencer and architectural state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= TBD_IDLE;
      busy_q <= 4'h0;
      instr_q <= 12'h000;
      dec_q <= 16'h0;
      res_q <= 8'h00;
    end
    else if (ce)
    begin
      case (state_q)
        TBD_IDLE:
          if (start)
          begin
            instr_q <= wd_q[11:0];
            state_q <= TBD_EXEC;
            busy_q <= 4'h0;
          end
        TBD_EXEC:
          if (busy_q == 4'h1) state_q <= TBD_IDLE;
          else if (busy_q == 4'h0) begin busy_q <= cyc_clks; dec_q <= dec_word; res_q <= r; end
          else busy_q <= busy_q - 4'h1;
        default: state_q <= TBD_IDLE;
      endcase
    end
  end

  // Commit pulse: first execution clock applies the results once
  wire commit = state_q == TBD_EXEC && busy_q == 4'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_q <= 8'h00;
      file_q <= 8'h00;
      {psa_q, zero_q, dc_q, carry_q} <= 4'h0;
      {timeout_q, powerdown_q} <= 2'b11;
      tristate_load_q <= `TBD_TRISTATE_LOAD_RESET;
      latch_q <= 8'h00;
      prescaler_clear <= 1'b0;
      standby <= 1'b0;
    end
    else if (ce)
    begin
      prescaler_clear <= commit && tmr_hit;
      if (commit)
      begin
        if (wr_acc) acc_q <= r;
        if (wr_file) file_q <= r;
        if (wr_file && fsel == `TBD_FILE_PORT) latch_q <= r;
        if (upd_z) zero_q <= r == 8'h00;
        if (upd_c) carry_q <= c_new;
        if (upd_dc) dc_q <= dc_new;
        if (tristate_load_hit) tristate_load_q <= acc_q;
        if (is_sleep) begin timeout_q <= 1'b1; powerdown_q <= 1'b0; standby <= 1'b1; end
        if (is_watchdog_clear) begin timeout_q <= 1'b1; powerdown_q <= 1'b1; end
      end
      else if (wr_opr)
      begin
        acc_q <= w_acc;
        file_q <= w_file;
        if (ws_q[2]) {psa_q, zero_q, dc_q, carry_q} <= wd_q[19:16];
      end
      if (start) standby <= 1'b0;
    end
  end

  // A one tristate bit releases the pin
  assign port_oe_n = tristate_load_q;
  assign port_out = latch_q;
endmodule // tbd_decoder

// File: tb/tbd_prog_mem.sv
// Program memory model that supplies the scenario instruction words
module tbd_prog_mem
(
  // Word index
  input wire logic [4:0] addr,
  // Instruction word
  output logic [11:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  // Words grouped by scenario except word 29, a t_ctrl word placed last; the index is the bench step
  localparam logic [11:0] ROM [0:29] = '{12'h1C3, 12'h1E3, 12'h083, 12'h143, 12'h103,
    12'h183, 12'hD5A, 12'hE5F, 12'hF33, 12'h343, 12'h303, 12'h2C3, 12'h3C3, 12'h603,
    12'h703, 12'h8A5, 12'h905, 12'hA05, 12'h004, 12'h040, 12'hC3C, 12'h000, 12'h002,
    12'h003, 12'h006, 12'h005, 12'h1E1, 12'h1C1, 12'h126, 12'h022};
  assign word = ROM[addr];
endmodule // tbd_prog_mem

// File: tb/tbd_decoder_chk.sv
// Port checker for the instruction decoder
module tbd_decoder_chk
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Side effects
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe_n,
  input wire logic prescaler_clear,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Properties
  // ----
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_oe_reset;
    $rose(aresetn) |-> port_oe_n == 8'hFF && port_out == 8'h00;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("port latches not reset");
  property p_presc_pulse;
    prescaler_clear |=> !prescaler_clear;
  endproperty
  a_presc_pulse: assert property (p_presc_pulse) else $error("clear pulse too long");
  property p_standby_presc;
    standby |-> !prescaler_clear;
  endproperty
  a_standby_presc: assert property (p_standby_presc) else $error("clear in standby");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_ready;
    arready == (ce && !rvalid);
  endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("read address ready wrong");
  property p_wr_resp;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  // Main scenarios seen
  c_standby: cover property ($rose(standby));
  c_presc: cover property (prescaler_clear);
  c_slverr: cover property (bvalid && bresp == 2'h2);
endmodule // tbd_decoder_chk
bind tbd_decoder tbd_decoder_chk i_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .port_out(port_out), .port_oe_n(port_oe_n),
  .prescaler_clear(prescaler_clear), .standby(standby));

// File: tb/tb_top.sv
// Testbench for the twelve-bit instruction decoder
`include "tbd_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Signals
  // ----
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic ce = 1'h1;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] port_pin_in = 8'h3C;
  logic [4:0] pc_idx = 5'h0;
  logic awready, wready, bvalid, arready, rvalid, prescaler_clear, standby;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, s;
  logic [7:0] port_out, port_oe_n;
  logic [11:0] word;
  int error_cnt = 0;
  int samples_checked = 0;
  int pclr_cnt = 0;
  // Clock and count of prescaler clear pulses
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) if (prescaler_clear === 1'h1) pclr_cnt <= pclr_cnt + 1;
  tbd_prog_mem i_pmem (.addr(pc_idx), .word(word));
  tbd_decoder #(.OSC_PER_CYCLE(4)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .port_pin_in(port_pin_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .prescaler_clear(prescaler_clear), .standby(standby));
  // ----
  // Bus and compare tasks
  // ----
  task automatic cmp(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write, each channel released when taken, with a slow response acceptance
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'h1)
      begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_done && wready === 1'h1)
      begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    repeat (2) @(posedge aclk);
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    cmp({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    repeat (2) @(posedge aclk);
    rready <= 1'h1;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    s = rdata;
    cmp({30'h0, rresp}, {30'h0, `TBD_AXI_OKAY});
  endtask
  // Run one stored word on an operand set, then judge the result word
  task automatic op(input logic [4:0] i, input logic [31:0] opnd, mask, exp);
    pc_idx = i;
    #1;
    wr(`TBD_OFS_OPERAND, opnd, `TBD_AXI_OKAY);
    wr(`TBD_OFS_INSTR, {20'h0, word}, `TBD_AXI_OKAY);
    do rd(`TBD_OFS_STATUS); while (s[8]);
    rd(`TBD_OFS_RESULT);
    cmp(s & mask, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_bus;
    wr(`TBD_OFS_RESULT, 32'h0, `TBD_AXI_SLVERR);
    wr(`TBD_OFS_OPERAND, 32'h3C217, `TBD_AXI_OKAY);
    rd(`TBD_OFS_OPERAND);
    cmp(s & 32'hFFFFF, 32'h3C217);
    pc_idx = 5'h10;
    #1;
    wr(`TBD_OFS_INSTR, {20'h0, word}, `TBD_AXI_OKAY);
    wr(`TBD_OFS_INSTR, {20'h0, word}, `TBD_AXI_SLVERR);
    do rd(`TBD_OFS_STATUS); while (s[8]);
  endtask
  task automatic t_arith;
    op(0, 32'hC217, 32'hFF00FF, 32'hE800D9);
    op(1, 32'h01FF, 32'hFF00FF, 32'hF70000);
    op(2, 32'h0503, 32'hFF00FF, 32'hEE0002);
  endtask
  task automatic t_logic;
    op(3, 32'h0FF0, 32'hF900FF, 32'h290000);
    op(4, 32'h0FF0, 32'hF900FF, 32'h2800FF);
    op(5, 32'h0FFF, 32'hF900FF, 32'h2800F0);
    op(6, 32'h0000, 32'hF900FF, 32'h28005A);
    op(7, 32'h00A3, 32'hF900FF, 32'h280003);
    op(8, 32'h0033, 32'hF900FF, 32'h290000);
    op(9, 32'h8100, 32'hF900FF, 32'h480002);
    op(10, 32'h8100, 32'hF900FF, 32'h480040);
  endtask
  task automatic t_skip;
    op(11, 32'h0100, 32'h30E00000, 32'h30000000);
    op(11, 32'h0200, 32'h30E00000, 32'h0);
    op(12, 32'hFF00, 32'h30E00000, 32'h30000000);
    op(12, 32'hFE00, 32'h30E00000, 32'h0);
    op(13, 32'hFE00, 32'h30E00000, 32'h30000000);
    op(13, 32'h0100, 32'h30E00000, 32'h0);
    op(14, 32'h0100, 32'h30E00000, 32'h30000000);
    op(14, 32'hFE00, 32'h30E00000, 32'h0);
  endtask
  task automatic t_ctrl;
    op(15, 32'h0, 32'hE0E800FF, 32'hE00800A5);
    op(16, 32'h0, 32'hE0E80000, 32'hE0000000);
    op(17, 32'h0, 32'hE0E80000, 32'h60000000);
    op(18, 32'h0, 32'h21E80000, 32'h1000000);
    rd(`TBD_OFS_STATUS);
    cmp({30'h0, s[10:9]}, 32'h3);
    op(19, 32'hFF, 32'h20F900FF, 32'h290000);
    op(20, 32'h0, 32'h20F900FF, 32'h8003C);
    op(21, 32'h0, 32'h20F80000, 32'h0);
    op(22, 32'h0, 32'h20F80000, 32'h0);
    op(29, 32'h0, 32'hE0100000, 32'hE0100000);
  endtask
  task automatic t_side;
    op(23, 32'h0, 32'h22000000, 32'h2000000);
    cmp({31'h0, standby}, 32'h1);
    rd(`TBD_OFS_STATUS);
    cmp({30'h0, s[10:9]}, 32'h2);
    op(24, 32'h5A, 32'h8000000, 32'h8000000);
    cmp({24'h0, port_oe_n}, 32'h5A);
    op(25, 32'hA5, 32'h8000000, 32'h0);
    cmp({24'h0, port_oe_n}, 32'h5A);
    op(26, 32'h80000, 32'h4000000, 32'h4000000);
    op(27, 32'h80000, 32'h4000000, 32'h0);
    op(26, 32'h0, 32'h4000000, 32'h0);
    cmp(pclr_cnt, 32'h1);
    op(28, 32'hFF00, 32'h1000FF, 32'h10003C);
    cmp({24'h0, port_out}, 32'h3C);
  endtask
  // Byte strobes, then a clock-enable freeze under a pending read
  task automatic t_ce;
    wr(`TBD_OFS_OPERAND, 32'h1234, `TBD_AXI_OKAY);
    wstrb <= 4'h1;
    wr(`TBD_OFS_OPERAND, 32'hFFFFFF55, `TBD_AXI_OKAY);
    wstrb <= 4'hF;
    ce <= 1'h0;
    fork
      rd(`TBD_OFS_OPERAND);
      begin
        repeat (5) @(posedge aclk);
        cmp({31'h0, rvalid}, 32'h0);
        ce <= 1'h1;
      end
    join
    cmp(s & 32'hFFFFF, 32'h1255);
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    error_cnt++;
    conclude;
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    #1;
    cmp({24'h0, port_oe_n}, 32'hFF);
    t_bus;
    t_arith;
    t_logic;
    t_skip;
    t_ctrl;
    t_side;
    t_ce;
    conclude;
  end
endmodule // tb_top
